/* File: core/autoneg_partner_nextpage_regs.sv */
// Partner ability, expansion and next-page registers behind the management port
`timescale 1ns/1ps

module autoneg_partner_nextpage_regs
(
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        mdc,
    input  wire logic                        mdio_i,
    output autoneg_regs_pkg::mdio_out_s      mdio_out,
    input  wire logic [4:0]                  phy_addr,
    input  wire logic                        preamble_suppress,
    input  wire logic                        negotiation_restart,
    input  wire logic                        base_word_valid,
    input  wire logic [15:0]                 base_word,
    input  wire logic                        page_received,
    input  wire logic                        np_word_valid,
    input  wire autoneg_regs_pkg::np_word_s  np_word,
    input  wire logic                        np_sent,
    input  wire logic                        parallel_fault,
    input  wire logic                        partner_negotiates,
    output autoneg_regs_pkg::np_word_s       next_page_tx
);
    import autoneg_regs_pkg::*;

    typedef enum {ST_PRE, ST_HDR, ST_TA, ST_DATA} frame_e;

    // ============================================================
    // Pin synchronisers
    logic [2:0]  mdc_sync_r;
    logic [2:0]  mdio_sync_r;
    logic        mdc_lvl_r;
    logic        mdio_lvl_r;
    wire         mdc_agree  = (mdc_sync_r[1] == mdc_sync_r[2]);
    wire         mdio_agree = (mdio_sync_r[1] == mdio_sync_r[2]);
    wire         mdc_rise   = mdc_agree && mdc_sync_r[2] && !mdc_lvl_r;
    wire         bit_in     = mdio_agree ? mdio_sync_r[2] : mdio_lvl_r;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Clock level starts high so a clock idling high is not taken for a rise
            mdc_sync_r  <= 3'h7;
            mdio_sync_r <= 3'h7;
            mdc_lvl_r   <= 1'b1;
            mdio_lvl_r  <= 1'b1;
        end
        else
        begin
            mdc_sync_r  <= {mdc_sync_r[1:0], mdc};
            mdio_sync_r <= {mdio_sync_r[1:0], mdio_i};
            if (mdc_agree)
                mdc_lvl_r <= mdc_sync_r[2];
            if (mdio_agree)
                mdio_lvl_r <= mdio_sync_r[2];
        end
    end

    // ============================================================
    // Register state
    logic [15:0] ability_r;
    np_word_s    np_rx_r;
    np_word_s    np_tx_r;
    logic        toggle_r;
    logic        pd_fault_r;
    logic        page_rx_r;
    logic        negotiates_r;

    // ============================================================
    // Frame state
    frame_e      state_r;
    frame_e      state_nxt;
    logic [5:0]  pre_cnt_r;
    logic [3:0]  cnt_r;
    logic [15:0] shift_r;
    logic        is_read_r;
    logic        is_write_r;
    logic [4:0]  reg_r;
    logic        mdio_o_r;
    logic        drive_r;

    // Header assembled from the twelve held bits and the thirteenth arriving now
    wire [12:0]  hdr        = {shift_r[11:0], bit_in};
    wire         hdr_start  = hdr[12];
    wire [1:0]   hdr_op     = hdr[11:10];
    wire [4:0]   hdr_phy    = hdr[9:5];
    wire [4:0]   hdr_reg    = hdr[4:0];
    wire         hdr_match  = hdr_start && (hdr_phy == phy_addr);
    wire         hdr_read   = hdr_match && (hdr_op == OP_READ);
    wire         hdr_write  = hdr_match && (hdr_op == OP_WRITE);
    wire         hdr_done   = mdc_rise && (state_r == ST_HDR) && (cnt_r == HDR_LAST);
    wire [5:0]   pre_need   = preamble_suppress ? PRE_SHORT : PRE_FULL;
    wire         pre_ok     = (pre_cnt_r >= pre_need);
    wire         data_done  = mdc_rise && (state_r == ST_DATA) && (cnt_r == DATA_LAST);
    // Word completed by the bit arriving now; the commit must see all sixteen
    wire [15:0]  data_word  = {shift_r[14:0], bit_in};
    wire         write_commit = data_done && is_write_r && (reg_r == ADDR_NP_TRANSMIT);

    // The read snapshot and the clear of latched bits happen on the same edge
    wire         exp_read_clr = hdr_done && hdr_read && (hdr_reg == ADDR_NEG_EXPANSION);

    // ============================================================
    // Read data views
    wire [15:0]  expansion_word;
    wire [15:0]  np_tx_word = {np_tx_r.more_pages, np_tx_r.ack, np_tx_r.message_page,
                               np_tx_r.can_comply_flag, toggle_r, np_tx_r.code};
    wire [15:0]  read_word;

    assign expansion_word[15:5]            = 11'h000;
    assign expansion_word[EXP_PD_FAULT]    = pd_fault_r;
    assign expansion_word[EXP_PARTNER_CAP] = ability_r[ABL_MORE_PAGES];
    assign expansion_word[EXP_LOCAL_CAP]   = 1'b1;
    assign expansion_word[EXP_PAGE_RX]     = page_rx_r;
    assign expansion_word[EXP_NEGOTIATES]  = negotiates_r;

    assign read_word = (hdr_reg == ADDR_PARTNER_ABILITY) ? ability_r :
                       (hdr_reg == ADDR_NEG_EXPANSION)   ? expansion_word :
                       (hdr_reg == ADDR_NP_TRANSMIT)     ? np_tx_word :
                       (hdr_reg == ADDR_PARTNER_NP)      ? np_rx_r :
                                                           WORD_ZERO;

    assign next_page_tx = '{more_pages:      np_tx_r.more_pages,
                            ack:             np_tx_r.ack,
                            message_page:    np_tx_r.message_page,
                            can_comply_flag: np_tx_r.can_comply_flag,
                            toggle:          toggle_r,
                            code:            np_tx_r.code};
    assign mdio_out = '{mdio_o: mdio_o_r, mdio_oe_n: !drive_r};

    // ============================================================
    // Partner ability and received next page
    // Reserved bits are masked at capture so they can never read back as one
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ability_r <= WORD_ZERO;
            np_rx_r   <= WORD_ZERO;
        end
        else if (negotiation_restart)
        begin
            ability_r <= WORD_ZERO;
            np_rx_r   <= WORD_ZERO;
        end
        else
        begin
            if (base_word_valid)
                ability_r <= base_word & ~ABL_RSVD_MASK;
            if (np_word_valid)
                np_rx_r <= np_word;
        end
    end

    // ============================================================
    // Expansion flags, fault and page ones latched; a new event outranks the clearing read
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pd_fault_r   <= 1'b0;
            page_rx_r    <= 1'b0;
            negotiates_r <= 1'b0;
        end
        else
        begin
            pd_fault_r   <= parallel_fault | (pd_fault_r & !exp_read_clr);
            page_rx_r    <= page_received | (page_rx_r & !exp_read_clr);
            negotiates_r <= partner_negotiates;
        end
    end

    // ============================================================
    // Next-page transmit word
    // The toggle flips per page sent; software writes to bit 11 are dropped
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            np_tx_r <= '{more_pages:      NP_MORE_RST,
                         ack:             NP_ACK_RST,
                         message_page:    NP_MSG_RST,
                         can_comply_flag: NP_COMPLY_RST,
                         toggle:          NP_TOGGLE_RST,
                         code:            NP_CODE_RST};
            toggle_r <= NP_TOGGLE_RST;
        end
        else
        begin
            if (write_commit)
            begin
                np_tx_r.more_pages      <= data_word[15];
                np_tx_r.ack             <= data_word[14];
                np_tx_r.message_page    <= data_word[13];
                np_tx_r.can_comply_flag <= data_word[12];
                np_tx_r.code            <= data_word[10:0];
            end
            if (negotiation_restart)
                toggle_r <= NP_TOGGLE_RST;
            else if (np_sent)
                toggle_r <= !toggle_r;
        end
    end

    // ============================================================
    // Management frame sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_PRE:
                if (mdc_rise && !bit_in && pre_ok)
                    state_nxt = ST_HDR;
            ST_HDR:
                if (hdr_done)
                    state_nxt = (hdr_read || hdr_write) ? ST_TA : ST_PRE;
            ST_TA:
                if (mdc_rise && cnt_r[0])
                    state_nxt = ST_DATA;
            ST_DATA:
                if (data_done)
                    state_nxt = ST_PRE;
            default:
                state_nxt = ST_PRE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ST_PRE;
            pre_cnt_r <= 6'h00;
        end
        else
        begin
            state_r <= state_nxt;
            // Preamble must be seen again before every frame
            if (state_r != ST_PRE)
                pre_cnt_r <= 6'h00;
            else if (mdc_rise)
                pre_cnt_r <= !bit_in ? 6'h00 :
                             (pre_cnt_r == PRE_FULL) ? pre_cnt_r : pre_cnt_r + 6'h01;
        end
    end

    // ============================================================
    // Bit counter and shift register, advanced by management clock rises
    // The read word is loaded at the header decode and held through the first
    // turnaround bit, so its top bit is still there when the device drives it on the second
    wire         shift_hold = (state_r == ST_TA) && is_read_r && !cnt_r[0];
    wire [15:0]  shift_nxt  = (hdr_done && hdr_read) ? read_word :
                              shift_hold              ? shift_r :
                                                        data_word;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_r   <= 4'h0;
            shift_r <= WORD_ZERO;
        end
        else if (mdc_rise)
        begin
            cnt_r   <= (state_nxt != state_r) ? 4'h0 : cnt_r + 4'h1;
            shift_r <= shift_nxt;
        end
    end

    // ============================================================
    // Decoded header kept for the turnaround and data phases
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            is_read_r  <= 1'b0;
            is_write_r <= 1'b0;
            reg_r      <= 5'h00;
        end
        else if (hdr_done)
        begin
            is_read_r  <= hdr_read;
            is_write_r <= hdr_write;
            reg_r      <= hdr_reg;
        end
    end

    // ============================================================
    // Pin drive; data leaves on the rising edge so it is steady when the
    // station samples on the next one
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mdio_o_r <= 1'b1;
            drive_r  <= 1'b0;
        end
        else if (mdc_rise)
        begin
            case (state_r)
                ST_TA:
                    if (is_read_r)
                    begin
                        drive_r  <= 1'b1;
                        mdio_o_r <= cnt_r[0] ? shift_r[15] : 1'b0;
                    end
                ST_DATA:
                    if (is_read_r)
                    begin
                        drive_r  <= !data_done;
                        mdio_o_r <= data_done ? 1'b1 : shift_r[15];
                    end
                default:
                begin
                    drive_r  <= 1'b0;
                    mdio_o_r <= 1'b1;
                end
            endcase
        end
    end

endmodule

/* File: core/autoneg_regs_pkg.sv */
// Constants and carrier types for the partner and next-page register bank
package autoneg_regs_pkg;

    // ============================================================
    // Register offsets on the management interface
    localparam logic [4:0] ADDR_PARTNER_ABILITY = 5'h05;
    localparam logic [4:0] ADDR_NEG_EXPANSION   = 5'h06;
    localparam logic [4:0] ADDR_NP_TRANSMIT     = 5'h07;
    localparam logic [4:0] ADDR_PARTNER_NP      = 5'h08;

    // ============================================================
    // Field positions
    localparam int ABL_MORE_PAGES   = 15;
    localparam int ABL_ACK          = 14;
    localparam int ABL_FAULT        = 13;
    localparam int ABL_FLOW         = 10;
    localparam int ABL_T4           = 9;
    localparam int ABL_TX_FDX       = 8;
    localparam int ABL_TX           = 7;
    localparam int ABL_10_FDX       = 6;
    localparam int ABL_10           = 5;
    localparam int ABL_CLASS_HI     = 4;
    localparam logic [15:0] ABL_RSVD_MASK = 16'h1800;
    localparam int EXP_PD_FAULT     = 4;
    localparam int EXP_PARTNER_CAP  = 3;
    localparam int EXP_LOCAL_CAP    = 2;
    localparam int EXP_PAGE_RX      = 1;
    localparam int EXP_NEGOTIATES   = 0;

    // ============================================================
    // Reset values
    localparam logic        NP_MORE_RST    = 1'b0;
    localparam logic        NP_ACK_RST     = 1'b0;
    localparam logic        NP_MSG_RST     = 1'b1;
    localparam logic        NP_COMPLY_RST  = 1'b0;
    localparam logic        NP_TOGGLE_RST  = 1'b0;
    localparam logic [10:0] NP_CODE_RST    = 11'h001;
    localparam logic [15:0] WORD_ZERO      = 16'h0000;

    // ============================================================
    // Management frame constants
    localparam logic [5:0] PRE_FULL  = 6'h20;
    localparam logic [5:0] PRE_SHORT = 6'h02;
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [3:0] HDR_LAST  = 4'hC;
    localparam logic [3:0] DATA_LAST = 4'hF;

    // Next-page word, same layout for transmit and received pages
    typedef struct packed {
        logic        more_pages;
        logic        ack;
        logic        message_page;
        logic        can_comply_flag;
        logic        toggle;
        logic [10:0] code;
    } np_word_s;

    // Management serial pins as seen by the device
    typedef struct packed {
        logic mdio_o;
        logic mdio_oe_n;
    } mdio_out_s;

endpackage

/* File: sim/autoneg_regs_properties.sv */
// Port checker for the partner and next-page register bank
`timescale 1ns/1ps
module autoneg_regs_properties
(
    input wire logic                        clk,
    input wire logic                        reset_n,
    input wire logic                        mdc,
    input wire logic                        negotiation_restart,
    input wire logic                        np_sent,
    input wire autoneg_regs_pkg::mdio_out_s mdio_out,
    input wire autoneg_regs_pkg::np_word_s  next_page_tx
);
    import autoneg_regs_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire        oe_n = mdio_out.mdio_oe_n;
    wire        dout = mdio_out.mdio_o;
    wire        tgl  = next_page_tx.toggle;
    wire [14:0] wr_bits = {next_page_tx[15:12], next_page_tx[10:0]};
    // Counts management clock rises seen while the device drives the pin
    logic [4:0] rise_cnt_r;
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            rise_cnt_r <= 5'h00;
        else
            rise_cnt_r <= oe_n ? 5'h00 : rise_cnt_r + 5'($rose(mdc));
    // =====
    // Sequences and properties
    sequence s_ta_start; $fell(oe_n); endsequence
    sequence s_ta_low; !dout; endsequence
    property p_reset_value; $rose(reset_n) |-> next_page_tx == 16'h2001 && oe_n && dout; endproperty
    property p_toggle_flip; np_sent && !negotiation_restart |=> tgl != $past(tgl); endproperty
    property p_toggle_hold; !np_sent && !negotiation_restart |=> $stable(tgl); endproperty
    property p_toggle_clear; negotiation_restart |=> !tgl; endproperty
    property p_idle_high; oe_n |-> dout; endproperty
    property p_ta_zero; s_ta_start |-> s_ta_low; endproperty
    property p_drive_span; $rose(oe_n) |-> $past(rise_cnt_r) == 5'h11; endproperty
    property p_change_after_rise; !oe_n && $changed(dout) |-> $past(mdc, 3); endproperty
    property p_write_commit; $changed(wr_bits) |-> $past(mdc, 3); endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("transmit word or pin wrong after reset");
    a_toggle_flip: assert property (p_toggle_flip)
        else $error("toggle did not flip");
    a_toggle_hold: assert property (p_toggle_hold)
        else $error("toggle changed without cause");
    a_toggle_clear: assert property (p_toggle_clear)
        else $error("toggle not cleared by restart");
    a_idle_high: assert property (p_idle_high)
        else $error("data pin low while released");
    a_ta_zero: assert property (p_ta_zero)
        else $error("turnaround not driven low");
    a_drive_span: assert property (p_drive_span)
        else $error("pin driven for wrong number of clock rises");
    a_change_after_rise: assert property (p_change_after_rise)
        else $error("driven bit changed away from a clock rise");
    a_write_commit: assert property (p_write_commit)
        else $error("transmit word changed without a write");
endmodule
bind autoneg_partner_nextpage_regs autoneg_regs_properties u_props
(
    .clk                 (clk),
    .reset_n             (reset_n),
    .mdc                 (mdc),
    .negotiation_restart (negotiation_restart),
    .np_sent             (np_sent),
    .mdio_out            (mdio_out),
    .next_page_tx        (next_page_tx)
);

/* File: sim/negotiation_partner_model.sv */
// Remote partner and negotiation engine model driving the event inputs
`timescale 1ns/1ps
module negotiation_partner_model
(
    input wire logic                  clk,
    output logic                      base_word_valid,
    output logic [15:0]               base_word,
    output logic                      page_received,
    output logic                      np_word_valid,
    output autoneg_regs_pkg::np_word_s np_word,
    output logic                      parallel_fault,
    output logic                      partner_negotiates
);
    import autoneg_regs_pkg::*;
    initial
    begin
        {base_word_valid, page_received, np_word_valid, parallel_fault} = 4'h0;
        base_word = 16'h0000;
        np_word = 16'h0000;
        partner_negotiates = 1'b0;
    end
    // Words stand for the strobe cycle only, then invert so a late capture shows
    task automatic send_base(input logic [15:0] w);
        base_word = w;
        base_word_valid = 1'b1;
        @(negedge clk);
        base_word_valid = 1'b0;
        base_word = ~w;
    endtask
    task automatic send_page(input np_word_s w);
        np_word = w;
        np_word_valid = 1'b1;
        @(negedge clk);
        np_word_valid = 1'b0;
        np_word = ~w;
    endtask
    task automatic pulse_events();
        {parallel_fault, page_received} = 2'h3;
        @(negedge clk);
        {parallel_fault, page_received} = 2'h0;
    endtask
    task automatic set_able(input logic v);
        partner_negotiates = v;
    endtask
endmodule

/* File: sim/autoneg_partner_nextpage_regs_tb_top.sv */
// Testbench for the partner and next-page register bank
`timescale 1ns/1ps
module autoneg_partner_nextpage_regs_tb_top;
    import autoneg_regs_pkg::*;
    logic clk, reset_n, mdc, bench_mdio, preamble_suppress, negotiation_restart, np_sent;
    logic bwv, prx, npv, pfault, pneg;
    logic [15:0] bw;
    np_word_s np_word, next_page_tx;
    mdio_out_s mdio_out;
    wire  mdio_i = mdio_out.mdio_oe_n ? bench_mdio : mdio_out.mdio_o;
    int   err_count = 0;
    int   n_compared = 0;
    autoneg_partner_nextpage_regs u_dut (.clk(clk), .reset_n(reset_n), .mdc(mdc),
        .mdio_i(mdio_i), .mdio_out(mdio_out), .phy_addr(5'h0B),
        .preamble_suppress(preamble_suppress), .negotiation_restart(negotiation_restart),
        .base_word_valid(bwv), .base_word(bw), .page_received(prx), .np_word_valid(npv),
        .np_word(np_word), .np_sent(np_sent), .parallel_fault(pfault),
        .partner_negotiates(pneg), .next_page_tx(next_page_tx));
    negotiation_partner_model u_partner (.clk(clk), .base_word_valid(bwv), .base_word(bw),
        .page_received(prx), .np_word_valid(npv), .np_word(np_word),
        .parallel_fault(pfault), .partner_negotiates(pneg));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // =====
    // Management frame tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Station samples just before its rise, where the driven bit has settled
    task automatic mbit(input logic b, output logic s);
        bench_mdio = b;
        mdc = 1'b0;
        repeat (8) @(negedge clk);
        s = mdio_i;
        mdc = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                         input int npre, output logic [15:0] q);
        logic        s;
        logic [31:0] bits;
        bits = {2'h1, rd ? OP_READ : OP_WRITE, 5'h0B, ra, rd ? 2'h3 : 2'h2, rd ? 16'hFFFF : wd};
        repeat (npre) mbit(1'b1, s);
        for (int i = 31; i >= 0; i--)
        begin
            mbit(bits[i], s);
            if (i < 16)
                q[i] = s;
        end
        bench_mdio = 1'b1;
    endtask
    task automatic rdchk(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] q;
        frame(1'b1, ra, 16'h0000, 32, q);
        check(q, exp);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d, input int npre);
        logic [15:0] q;
        frame(1'b0, ra, d, npre, q);
    endtask
    task automatic restart();
        negotiation_restart = 1'b1;
        @(negedge clk);
        negotiation_restart = 1'b0;
    endtask
    // =====
    // Scenarios
    task automatic t_reset_values();
        rdchk(ADDR_PARTNER_ABILITY, 16'h0000);
        rdchk(ADDR_NEG_EXPANSION, 16'h0004);
        rdchk(ADDR_NP_TRANSMIT, 16'h2001);
        rdchk(ADDR_PARTNER_NP, 16'h0000);
        rdchk(5'h1F, 16'h0000);
    endtask
    task automatic t_ability();
        logic [15:0] w;
        u_partner.set_able(1'b1);
        for (int i = 0; i < 2; i++)
        begin
            w = (i == 0) ? 16'hFFFF : 16'h5A55;
            u_partner.send_base(w);
            wr(ADDR_PARTNER_ABILITY, ~w, 32);
            rdchk(ADDR_PARTNER_ABILITY, w & 16'hE7FF);
            rdchk(ADDR_NEG_EXPANSION, {12'h000, w[15], 3'h5});
        end
        restart();
        u_partner.set_able(1'b0);
        rdchk(ADDR_PARTNER_ABILITY, 16'h0000);
        rdchk(ADDR_NEG_EXPANSION, 16'h0004);
    endtask
    task automatic t_latched();
        logic [15:0] r1, r2;
        u_partner.pulse_events();
        rdchk(ADDR_NEG_EXPANSION, 16'h0016);
        rdchk(ADDR_NEG_EXPANSION, 16'h0004);
        for (int off = 722; off < 738; off++)
        begin
            fork
                frame(1'b1, ADDR_NEG_EXPANSION, 16'h0000, 32, r1);
                begin
                    repeat (off) @(negedge clk);
                    u_partner.pulse_events();
                end
            join
            frame(1'b1, ADDR_NEG_EXPANSION, 16'h0000, 32, r2);
            check({14'h0, r1[4] ^ r2[4], r1[1] ^ r2[1]}, 16'h0003);
        end
    endtask
    task automatic t_transmit();
        wr(ADDR_NP_TRANSMIT, 16'hFFFF, 32);
        rdchk(ADDR_NP_TRANSMIT, 16'hF7FF);
        check(next_page_tx, 16'hF7FF);
        wr(ADDR_NP_TRANSMIT, 16'h0000, 32);
        np_sent = 1'b1;
        @(negedge clk);
        np_sent = 1'b0;
        rdchk(ADDR_NP_TRANSMIT, 16'h0800);
        restart();
        rdchk(ADDR_NP_TRANSMIT, 16'h0000);
        wr(ADDR_NP_TRANSMIT, 16'h1234, 2);
        rdchk(ADDR_NP_TRANSMIT, 16'h0000);
        preamble_suppress = 1'b1;
        wr(ADDR_NP_TRANSMIT, 16'h1234, 2);
        rdchk(ADDR_NP_TRANSMIT, 16'h1234);
        preamble_suppress = 1'b0;
    endtask
    task automatic t_partner_page();
        u_partner.send_page(16'hFFFF);
        wr(ADDR_PARTNER_NP, 16'h0000, 32);
        rdchk(ADDR_PARTNER_NP, 16'hFFFF);
        restart();
        rdchk(ADDR_PARTNER_NP, 16'h0000);
        rdchk(ADDR_NP_TRANSMIT, 16'h1234);
    endtask
    // Chip reset in mid-run must clear latched, captured and written state
    task automatic t_chip_reset();
        u_partner.pulse_events();
        u_partner.send_base(16'hFFFF);
        u_partner.send_page(16'hFFFF);
        wr(ADDR_NP_TRANSMIT, 16'hFFFF, 32);
        reset_n = 1'b0;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        rdchk(ADDR_NEG_EXPANSION, 16'h0004);
        rdchk(ADDR_PARTNER_ABILITY, 16'h0000);
        rdchk(ADDR_PARTNER_NP, 16'h0000);
        rdchk(ADDR_NP_TRANSMIT, 16'h2001);
    endtask
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (90000) @(posedge clk);
        err_count++;
        close_out();
    end
    initial
    begin
        {reset_n, mdc, bench_mdio, preamble_suppress, negotiation_restart, np_sent} = 6'h08;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        check(next_page_tx, 16'h2001);
        t_reset_values();
        t_ability();
        t_latched();
        t_transmit();
        t_partner_page();
        t_chip_reset();
        close_out();
    end
endmodule
